// >>> p2c_map.svh
// Register map, field positions and reset values of the port-two pin configuration block
// Assumes the host includes it by bare name from any design or test file
`ifndef P2C_MAP_SVH
`define P2C_MAP_SVH

`define P2C_ADDR_CONFIG 8'h97
`define P2C_RESET_VALUE 8'h00
`define P2C_MODE_HI 7
`define P2C_MODE_LO 5
`define P2C_IN_MODE_HI 6
`define P2C_DIR_BIT 4
`define P2C_PTR_LOAD_BIT 3
`define P2C_SEL_HI 2
`define P2C_SEL_LO 0
`define P2C_OUT_NORMAL 3'h0
`define P2C_OUT_HIGH 3'h3
`define P2C_IN_NOPULL 2'h0
`define P2C_IN_PULLDOWN 2'h1
`define P2C_IN_PULLUP 2'h2
`define P2C_IN_OFF 2'h3

`endif

// >>> p2c_pkg.sv
// Types shared by the port-two pin configuration block
// Assumes nothing beyond a SystemVerilog compiler
package p2c_pkg;
  typedef enum logic [1:0] {
    P2C_PKG_LARGE,
    P2C_PKG_MID,
    P2C_PKG_SMALL
  } p2c_package_t;
endpackage

// >>> p2c_pin_slot.sv
// One pin's stored output and input modes and its pad control decode
// Assumes a write enable that is already qualified for this pin
`timescale 1ns/100ps
`include "p2c_map.svh"
module p2c_pin_slot (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Update
  input wire logic wr_en,
  input wire logic wr_dir_in,
  input wire logic [2:0] wr_mode,
  // Stored modes
  output logic [2:0] out_mode,
  output logic [1:0] in_mode,
  // Pad controls, decoded from the stored modes
  output logic high_drive,
  output logic in_buf_en,
  output logic pull_down,
  output logic pull_up
);
  // ****************************************
  // Mode storage
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_mode <= 3'h0;
    end else if (wr_en && !wr_dir_in) begin
      out_mode <= wr_mode;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_mode <= 2'h0;
    end else if (wr_en && wr_dir_in) begin
      in_mode <= wr_mode[1:0];
    end
  end

  // ****************************************
  // Pad decode
  // ****************************************
  always_comb begin
    high_drive = (out_mode == `P2C_OUT_HIGH);
    in_buf_en = (in_mode != `P2C_IN_OFF);
    pull_down = (in_mode == `P2C_IN_PULLDOWN);
    pull_up = (in_mode == `P2C_IN_PULLUP);
  end
endmodule

// >>> p2c_port2_config.sv
// Indirect pin configuration register of the eight-pin general-purpose port two
// Assumes a single-cycle register port on clk; the package variant is a static strap
`timescale 1ns/100ps
`include "p2c_map.svh"
module p2c_port2_config
  import p2c_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Package variant strap
  input wire p2c_package_t pkg_variant,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pad controls, one bit per pin
  output logic [NUM_PINS-1:0] pad_high_drive,
  output logic [NUM_PINS-1:0] pad_in_buf_en,
  output logic [NUM_PINS-1:0] pad_pull_down,
  output logic [NUM_PINS-1:0] pad_pull_up,
  // Status
  output logic [2:0] read_pointer_pin,
  output logic read_pointer_dir_in,
  output logic port_enabled
);
  // ****************************************
  // Write decode
  // ****************************************
  logic hit_wr;
  p2c_package_t pkg_s1_reg;
  p2c_package_t pkg_s2_reg;
  p2c_package_t pkg_s3_reg;
  logic pkg_reg;
  logic ptr_load;
  logic dir_in;
  logic [2:0] pin_select;
  logic [2:0] pin_function_mode;
  logic [2:0] ptr_pin_reg;
  logic ptr_dir_reg;
  logic [NUM_PINS-1:0][2:0] out_mode;
  logic [NUM_PINS-1:0][1:0] in_mode;
  logic [NUM_PINS-1:0] high_drive;
  logic [NUM_PINS-1:0] in_buf_en;
  logic [NUM_PINS-1:0] pull_down;
  logic [NUM_PINS-1:0] pull_up;
  logic [7:0] rdata_next;

  // ****************************************
  // Package strap synchroniser
  // ****************************************
  // The strap is a pin: three stages, and a value counts only once the last two agree.
  // Stages reset to a small package so the port stays closed until the strap has settled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkg_s1_reg <= P2C_PKG_SMALL;
    end else begin
      pkg_s1_reg <= pkg_variant;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkg_s2_reg <= P2C_PKG_SMALL;
    end else begin
      pkg_s2_reg <= pkg_s1_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkg_s3_reg <= P2C_PKG_SMALL;
    end else begin
      pkg_s3_reg <= pkg_s2_reg;
    end
  end

  // Only the largest package implements the eight pins of this port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkg_reg <= 1'b0;
    end else if (pkg_s2_reg == pkg_s3_reg) begin
      pkg_reg <= (pkg_s3_reg == P2C_PKG_LARGE);
    end
  end

  always_comb begin
    hit_wr = reg_wr && (reg_addr == `P2C_ADDR_CONFIG) && pkg_reg;
    ptr_load = reg_wdata[`P2C_PTR_LOAD_BIT];
    dir_in = reg_wdata[`P2C_DIR_BIT];
    pin_select = reg_wdata[`P2C_SEL_HI:`P2C_SEL_LO];
    pin_function_mode = reg_wdata[`P2C_MODE_HI:`P2C_MODE_LO];
  end

  // ****************************************
  // Read pointer
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_pin_reg <= 3'h0;
      ptr_dir_reg <= 1'b0;
    end else if (hit_wr && ptr_load) begin
      ptr_pin_reg <= pin_select;
      ptr_dir_reg <= dir_in;
    end
  end

  // ****************************************
  // Pin slots
  // ****************************************
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      p2c_pin_slot u_slot (
        .clk(clk),
        .rst_n(rst_n),
        // Pointer loads never touch a mode
        .wr_en(hit_wr && !ptr_load && (pin_select == 3'(i))),
        .wr_dir_in(dir_in),
        .wr_mode(pin_function_mode),
        .out_mode(out_mode[i]),
        .in_mode(in_mode[i]),
        .high_drive(high_drive[i]),
        .in_buf_en(in_buf_en[i]),
        .pull_down(pull_down[i]),
        .pull_up(pull_up[i])
      );
    end
  endgenerate

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdata_next = `P2C_RESET_VALUE;
    if (pkg_reg && (reg_addr == `P2C_ADDR_CONFIG)) begin
      if (ptr_dir_reg) begin
        rdata_next[`P2C_IN_MODE_HI:`P2C_MODE_LO] = in_mode[ptr_pin_reg];
      end else begin
        rdata_next[`P2C_MODE_HI:`P2C_MODE_LO] = out_mode[ptr_pin_reg];
      end
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Pads of an unimplemented port are held released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_high_drive <= '0;
    end else begin
      pad_high_drive <= high_drive & {NUM_PINS{pkg_reg}};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_in_buf_en <= '0;
    end else begin
      pad_in_buf_en <= in_buf_en & {NUM_PINS{pkg_reg}};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_pull_down <= '0;
    end else begin
      pad_pull_down <= pull_down & {NUM_PINS{pkg_reg}};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_pull_up <= '0;
    end else begin
      pad_pull_up <= pull_up & {NUM_PINS{pkg_reg}};
    end
  end

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_pointer_pin <= 3'h0;
    end else begin
      read_pointer_pin <= ptr_pin_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_pointer_dir_in <= 1'b0;
    end else begin
      read_pointer_dir_in <= ptr_dir_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_enabled <= 1'b0;
    end else begin
      port_enabled <= pkg_reg;
    end
  end
endmodule

// >>> p2c_port2_config_assertions.sv
// Checker of the port-two pin configuration register
// Assumes it is bound to p2c_port2_config
`timescale 1ns/100ps
module p2c_port2_config_assertions
  import p2c_pkg::*;
#(parameter int NUM_PINS = 8) (
  // Watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire p2c_package_t pkg_variant,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_PINS-1:0] pad_high_drive,
  input wire logic [NUM_PINS-1:0] pad_in_buf_en,
  input wire logic [NUM_PINS-1:0] pad_pull_down,
  input wire logic [NUM_PINS-1:0] pad_pull_up,
  input wire logic [2:0] read_pointer_pin,
  input wire logic read_pointer_dir_in,
  input wire logic port_enabled
);
  wire logic wr = reg_wr && reg_addr == 8'h97 && port_enabled;
  wire logic ld = wr && reg_wdata[3];
  wire logic mw = wr && !reg_wdata[3];
  wire logic iw = mw && reg_wdata[4];
  wire logic [2:0] p = reg_wdata[2:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_ptr_load: assert property (ld |-> ##2 {read_pointer_pin, read_pointer_dir_in} ==
    $past({reg_wdata[2:0], reg_wdata[4]}, 2)) else $error("pointer not loaded");
  chk_ptr_hold: assert property ($changed({read_pointer_pin, read_pointer_dir_in}) |-> $past(ld, 2))
    else $error("pointer changed without load");
  chk_drive_set: assert property (mw && !reg_wdata[4] |-> ##2
    pad_high_drive[$past(p, 2)] == ($past(reg_wdata[7:5], 2) == 3'h3)) else $error("drive mode wrong");
  chk_pull_set: assert property (iw |-> ##2 {pad_pull_up[$past(p, 2)], pad_pull_down[$past(p, 2)]} ==
    {$past(reg_wdata[6:5], 2) == 2'h2, $past(reg_wdata[6:5], 2) == 2'h1}) else $error("pull wrong");
  chk_bufen_set: assert property (iw |-> ##2
    pad_in_buf_en[$past(p, 2)] == ($past(reg_wdata[6:5], 2) != 2'h3)) else $error("buffer wrong");
  chk_pads_hold: assert property ($changed(pad_high_drive) |-> $past(mw, 2))
    else $error("drive changed without mode write");
  chk_pkg_off: assert property (pkg_variant != P2C_PKG_LARGE |-> ##2 !port_enabled)
    else $error("port enabled in small package");
endmodule

// >>> p2c_port2_config_bench.sv
// Self-checking bench of the port-two pin configuration register
// Assumes the design and checker files are compiled first
`timescale 1ns/100ps
module p2c_port2_config_bench;
  import p2c_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 8'h97, reg_wdata = 8'h00;
  p2c_package_t pkg_variant = P2C_PKG_LARGE;
  wire logic [7:0] reg_rdata, hd, be, pd, pu;
  wire logic [2:0] rp;
  wire logic rpd, pe;
  int error_cnt = 0, checked = 0;
  always #4 clk = ~clk;
  p2c_port2_config dut_u (.clk(clk), .rst_n(rst_n), .pkg_variant(pkg_variant), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_high_drive(hd),
    .pad_in_buf_en(be), .pad_pull_down(pd), .pad_pull_up(pu), .read_pointer_pin(rp),
    .read_pointer_dir_in(rpd), .port_enabled(pe));
  task automatic chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask
  task automatic rst(input p2c_package_t k);
    rst_n <= 1'b0;
    pkg_variant <= k;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    summarize;
  end
  initial begin
    rst(P2C_PKG_LARGE);
    rd("reset read", 8'h00);
    chk("reset pointer", {4'h0, rpd, rp}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr({i[0] ? 3'h3 : 3'h0, 2'b00, i[2:0]});
      wr({1'b1, i[1:0], 2'b10, i[2:0]});
      wr({3'h7, 2'b01, i[2:0]});
    end
    reg_addr <= 8'h96;
    wr(8'h60);
    rd("unmapped read", 8'h00);
    reg_addr <= 8'h97;
    repeat (2) @(posedge clk);
    #1 chk("high drive", hd, 8'hAA);
    chk("pull down", pd, 8'h22);
    chk("pull up", pu, 8'h44);
    chk("input buffer", be, 8'h77);
    for (int i = 0; i < 16; i++) begin
      wr({3'h0, i[3], 1'b1, i[2:0]});
      rd("mode read", i[3] ? {1'b0, i[1:0], 5'h00} : {i[0] ? 3'h3 : 3'h0, 5'h00});
    end
    wr(8'h63);
    rd("pointer kept", 8'h60);
    for (int k = 1; k < 3; k++) begin
      rst(p2c_package_t'(k));
      wr(8'h63);
      rd("small read", 8'h00);
      repeat (2) @(posedge clk);
      #1 chk("small pads", {hd[6:0], pe}, 8'h00);
    end
    summarize;
  end
endmodule
bind p2c_port2_config p2c_port2_config_assertions #(.NUM_PINS(NUM_PINS)) chk_u (.*);
